// *** inc/rdse_regs.vh ***
`ifndef RDSE_REGS_VH
`define RDSE_REGS_VH

// ----------------------------------------
// Status codes
// ----------------------------------------
`define RDSE_ST_LAST_Q_PAGE 4'h0
`define RDSE_ST_PAGE_CROSS 4'h1
`define RDSE_ST_HDR_END 4'h2
`define RDSE_ST_PAGE_HDR 4'h3
`define RDSE_ST_NORM_PLAIN 4'h4
`define RDSE_ST_NORM_BURST 4'h5
`define RDSE_ST_NORM_THRESH 4'h6
`define RDSE_ST_NORM_SERVICE 4'h7
`define RDSE_ST_NO_DATA 4'h8
`define RDSE_ST_NO_HDR 4'h9
`define RDSE_ST_HDR_NO_INFO 4'ha
`define RDSE_ST_NO_INFO 4'hb
`define RDSE_ST_OVERRUN 4'hc
`define RDSE_ST_BAD_FRAME 4'hd
`define RDSE_ST_PARITY 4'he
`define RDSE_ST_INTERNAL 4'hf

// ----------------------------------------
// Part tags
// ----------------------------------------
`define RDSE_PART_LAST 2'h0
`define RDSE_PART_MIDDLE 2'h1
`define RDSE_PART_FIRST 2'h2
`define RDSE_PART_ONLY 2'h3

// ----------------------------------------
// Descriptor word layout
// ----------------------------------------
`define RDSE_DESC_W 6
`define RDSE_DESC_PART_HI 5
`define RDSE_DESC_PART_LO 4
`define RDSE_DESC_STAT_HI 3
`define RDSE_DESC_STAT_LO 0
`define RDSE_FIFO_DEPTH 16
`define RDSE_FIFO_AW 4
`define RDSE_UNIT_EVT_W 16

`endif

// *** tb/rdse_chk.sv ***
`timescale 1ns/10ps
module rdse_chk (
    input wire core_clk,
    input wire rst_n,
    input wire unit_valid,
    input wire unit_ready,
    input wire unit_frame_end,
    input wire input_unit_descriptor_valid,
    input wire input_unit_descriptor_ready,
    input wire [1:0] input_unit_descriptor_part,
    input wire [3:0] frame_status_code,
    input wire discard_active,
    input wire fault_seen
);
    wire dv = input_unit_descriptor_valid;
    wire dr = input_unit_descriptor_ready;
    wire [1:0] pt = input_unit_descriptor_part;
    wire [3:0] cd = frame_status_code;
    wire ends = pt == 2'h0 || pt == 2'h3;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    chk_mid_nonzero: assert property (dv && pt == 2'h1 |-> cd != 4'h0)
        else $error("zero code in middle part");
    chk_zero_last: assert property (dv && cd == 4'h0 |-> ends)
        else $error("zero code not closing");
    chk_cross_part: assert property (dv && cd == 4'h1 |-> pt[1] ^ pt[0])
        else $error("page cross tag wrong");
    chk_end_part: assert property (dv && cd[3:2] != 2'h0 |-> ends)
        else $error("end code not closing");
    chk_desc_hold: assert property (dv && !dr |=> dv && $stable(pt) && $stable(cd))
        else $error("descriptor changed while held");
    chk_fault_flag: assert property (dv && dr && cd == 4'hf |=> fault_seen)
        else $error("fault flag missing");
    chk_fault_sticky: assert property (fault_seen |=> fault_seen)
        else $error("fault flag dropped");
    chk_end_answer: assert property (unit_valid && unit_ready && unit_frame_end
        && !discard_active && !dv |-> ##[1:3] dv)
        else $error("frame end gave no descriptor");
    chk_reset_clear: assert property (disable iff (1'b0) !rst_n |=> !dv && !fault_seen)
        else $error("reset left state");
    cov_zero: cover property (dv && dr && cd == 4'h0);
    cov_full: cover property (unit_valid && !unit_ready);
    cov_fault: cover property (dv && dr && cd == 4'hf);
endmodule
bind rdse_status_encoder rdse_chk i_rdse_chk (.core_clk(core_clk), .rst_n(rst_n),
    .unit_valid(unit_valid), .unit_ready(unit_ready), .unit_frame_end(unit_frame_end),
    .input_unit_descriptor_valid(input_unit_descriptor_valid),
    .input_unit_descriptor_ready(input_unit_descriptor_ready),
    .input_unit_descriptor_part(input_unit_descriptor_part),
    .frame_status_code(frame_status_code), .discard_active(discard_active),
    .fault_seen(fault_seen));

// *** tb/rdse_host.sv ***
`timescale 1ns/10ps
module rdse_host (
    input wire core_clk,
    input wire rst_n,
    input wire stall,
    input wire desc_valid,
    input wire [1:0] desc_part,
    input wire [3:0] desc_code,
    output reg desc_ready,
    output reg reset_req
);
    logic [5:0] seen [$];
    int dropped = 0;
    initial desc_ready = 1'b0;
    initial reset_req = 1'b0;
    // Accepts at random moments so that the encoder meets back-pressure.
    always @(negedge core_clk) begin
        desc_ready <= !stall && rst_n && ($urandom % 3 != 0);
    end
    always @(posedge core_clk) begin
        if (rst_n && desc_valid && desc_ready) begin
            seen.push_back({desc_part, desc_code});
            if (desc_code[3:2] == 2'h3) dropped++;
            if (desc_code == 4'hf) reset_req <= 1'b1;
        end
    end
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/10ps
module testbench;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic unit_valid = 1'b0;
    logic stall = 1'b0;
    logic [20:0] s = '0;
    logic hdr, info, svc, disc;
    wire unit_ready, dv, dr, discard_active, fault_seen;
    wire [1:0] pt;
    wire [3:0] cd;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [5:0] exp_q [$];
    always #50 core_clk = ~core_clk;
    rdse_status_encoder i_rdse_status_encoder (.core_clk(core_clk), .rst_n(rst_n),
        .unit_valid(unit_valid), .unit_ready(unit_ready), .unit_page_cross(s[0]),
        .unit_header_end(s[1]), .unit_frame_end(s[2]), .unit_first(s[3]),
        .unit_queue_last(s[4]), .unit_is_info(s[5]), .ev_burst_boundary(s[6]),
        .ev_threshold(s[7]), .ev_mac_reset_event(s[8]), .ev_token(s[9]),
        .ev_mac_frame(s[10]), .ev_ring_op_change(s[11]), .ev_no_data_space(s[12]),
        .ev_no_unit_space(s[13]), .ev_fifo_overrun(s[14]), .ev_bad_length(s[15]),
        .ev_bad_fcs(s[16]), .ev_parity_error(s[17]), .ev_internal_fault(s[18]),
        .sort_mode(s[19]), .parity_check_enable(s[20]), .input_unit_descriptor_valid(dv),
        .input_unit_descriptor_ready(dr), .input_unit_descriptor_part(pt),
        .frame_status_code(cd), .discard_active(discard_active), .fault_seen(fault_seen));
    rdse_host i_rdse_host (.core_clk(core_clk), .rst_n(rst_n), .stall(stall), .desc_valid(dv),
        .desc_part(pt), .desc_code(cd), .desc_ready(dr), .reset_req());
    // Returns an emit flag above the four-bit status code.
    function automatic logic [4:0] code_of(logic [20:0] u, logic h, logic i, logic sv);
        if (u[18]) return 5'h1f;
        if (u[17] && u[20]) return 5'h1e;
        if (u[14]) return 5'h1c;
        if (u[15] || u[16]) return 5'h1d;
        if (u[19] && (u[12] || u[13])) return !h ? 5'h19 : (!i ? 5'h1a : 5'h1b);
        if (!u[19] && u[12]) return 5'h18;
        if (u[2]) return (sv || |u[11:8]) ? 5'h17 : u[7] ? 5'h16 : u[6] ? 5'h15 : 5'h14;
        if (u[0] && u[4]) return 5'h10;
        if (u[0] || u[1]) return {3'h4, u[1], u[0]};
        return 5'h00;
    endfunction
    task automatic take_model(logic [20:0] u);
        logic [4:0] r;
        logic e;
        if (disc && !u[3]) begin
            svc = svc || |u[11:8];
            disc = !u[2];
            return;
        end
        r = code_of(u, (hdr && !u[3]) || u[1], info && !u[3], svc);
        e = u[2] || r[3] || r[3:0] == 4'h0;
        if (r[4]) exp_q.push_back({u[3], u[3] ^ !e, r[3:0]});
        svc = (r[4:2] == 3'h5) ? |u[11:8] : (svc || |u[11:8]);
        disc = r[4] && !u[2] && (r[3] || r[3:0] == 4'h0);
        hdr = !u[2] && ((hdr && !u[3]) || u[1]);
        info = !u[2] && ((info && !u[3]) || u[5]);
    endtask
    task automatic send(logic [20:0] u);
        int n;
        n = 0;
        s = u;
        unit_valid = 1'b1;
        while (!unit_ready && n < 300) begin
            @(negedge core_clk);
            n++;
        end
        if (!unit_ready) failures++;
        @(posedge core_clk);
        take_model(u);
        @(negedge core_clk);
    endtask
    task automatic idle(logic [20:0] u);
        s = u;
        unit_valid = 1'b0;
        svc = svc || |u[11:8];
        @(negedge core_clk);
    endtask
    task automatic cmp_desc(string what, logic [5:0] e, logic [5:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cmp_flag(string what, logic e, logic g);
        cmp_desc(what, {5'h0, e}, {5'h0, g});
    endtask
    task automatic drain_check();
        int n;
        idle('0);
        for (n = 0; n < 900 && (dv || i_rdse_host.seen.size() < exp_q.size()); n++)
            @(negedge core_clk);
        cmp_flag("count", 1'b1, exp_q.size() == i_rdse_host.seen.size());
        while (exp_q.size() > 0 && i_rdse_host.seen.size() > 0)
            cmp_desc("desc", exp_q.pop_front(), i_rdse_host.seen.pop_front());
        exp_q.delete();
        i_rdse_host.seen.delete();
    endtask
    task automatic print_verdict();
        if (failures == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            print_verdict();
        end
    end
    initial begin
        logic [20:0] u;
        logic [4:0] r;
        int n;
        {hdr, info, svc, disc} = '0;
        void'($urandom(32'hd1b7));
        repeat (8) @(negedge core_clk);
        rst_n = 1'b1;
        send(21'h9);
        send(21'h1);
        send(21'h2);
        send(21'h3);
        send(21'h4);
        send(21'h9);
        send(21'h11);
        send(21'h2);
        cmp_flag("discard", 1'b1, discard_active);
        send(21'h8_000a);
        send(21'h8_1000);
        send(21'h8_000a);
        send(21'h8_0021);
        send(21'h8_1020);
        send(21'h8_1008);
        send(21'h9);
        send(21'h1000);
        send(21'h200c);
        idle(21'h200);
        idle(21'h0);
        send(21'hc);
        send(21'hc);
        send(21'h2_000c);
        send(21'h12_000c);
        send(21'h4_0008);
        drain_check();
        cmp_flag("fault", 1'b1, fault_seen);
        cmp_flag("reset request", 1'b1, i_rdse_host.reset_req);
        stall = 1'b1;
        for (n = 0; n < 40 && unit_ready; n++)
            send(n == 0 ? 21'h9 : 21'h1);
        cmp_flag("full", 1'b0, unit_ready);
        stall = 1'b0;
        drain_check();
        repeat (300) begin
            u = (21'($urandom) & 21'h1f_fff1) | 21'hc;
            if ($urandom % 2) u = u & ~21'h7_f000;
            r = code_of(u, 1'b0, 1'b0, svc);
            if (r[3:2] != 2'h1) u = u & ~21'hf00;
            send(u);
        end
        drain_check();
        rst_n = 1'b0;
        {hdr, info, svc, disc} = '0;
        repeat (8) @(negedge core_clk);
        cmp_flag("fault cleared", 1'b0, fault_seen);
        rst_n = 1'b1;
        send(21'hc);
        drain_check();
        print_verdict();
    end
endmodule

// *** verilog/rdse_fifo.v ***
`timescale 1ns/10ps
module rdse_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire core_clk,
    input wire rst_n,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output reg out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [AW:0] wr_ptr_reg;
    reg [AW:0] rd_ptr_reg;
    wire [AW:0] count;
    wire push;
    wire pop;
    wire out_free;

    assign count = wr_ptr_reg - rd_ptr_reg;
    assign in_ready = (count != DEPTH[AW:0]);
    assign push = in_valid && in_ready;
    assign out_free = !out_valid || out_ready;
    assign pop = (count != {(AW+1){1'b0}}) && out_free;

    always @(posedge core_clk) begin
        if (!rst_n) begin
            wr_ptr_reg <= {(AW+1){1'b0}};
            rd_ptr_reg <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end

    rdse_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
        .core_clk(core_clk),
        .wr_en(push),
        .wr_addr(wr_ptr_reg[AW-1:0]),
        .wr_data(in_data),
        .rd_en(pop),
        .rd_addr(rd_ptr_reg[AW-1:0]),
        .rd_data(out_data)
    );
endmodule

// *** verilog/rdse_mem.v ***
`timescale 1ns/10ps
module rdse_mem #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire core_clk,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [WIDTH-1:0] wr_data,
    input wire rd_en,
    input wire [AW-1:0] rd_addr,
    output reg [WIDTH-1:0] rd_data
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];

    always @(posedge core_clk) begin
        if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
        if (rd_en) begin
            rd_data <= mem_reg[rd_addr];
        end
    end
endmodule

// *** verilog/rdse_status_encoder.v ***
`timescale 1ns/10ps
`include "rdse_regs.vh"

// Functional notes
// - Last queue entry with page cross: 0000, discard
// - Never 0000 in a middle descriptor
// - 0001 page cross, first or middle only
// - 0010 marks last unit of header
// - 0011 when page cross meets header end
// - 0100 normal end, no breakpoint
// - 0101 normal end at burst boundary
// - 0110 normal end at copy threshold
// - 0111 normal end after service events
// - 1000 partial copy, sort mode off only
// - 1001 sort mode, header space lacking
// - 1010 header copied, no info copied
// - 1011 info space ran out mid info
// - 1100 receive FIFO overrun during copy
// - 1101 bad length or bad check sequence
// - 1110 parity error, only when enabled
// - 1111 internal fault while receiving
// - Two bit part tag per descriptor
module rdse_status_encoder #(
    parameter FIFO_DEPTH = `RDSE_FIFO_DEPTH,
    parameter FIFO_AW = `RDSE_FIFO_AW
) (
    input wire core_clk,
    input wire rst_n,
    input wire unit_valid,
    output wire unit_ready,
    input wire unit_page_cross,
    input wire unit_header_end,
    input wire unit_frame_end,
    input wire unit_first,
    input wire unit_queue_last,
    input wire unit_is_info,
    input wire ev_burst_boundary,
    input wire ev_threshold,
    input wire ev_mac_reset_event,
    input wire ev_token,
    input wire ev_mac_frame,
    input wire ev_ring_op_change,
    input wire ev_no_data_space,
    input wire ev_no_unit_space,
    input wire ev_fifo_overrun,
    input wire ev_bad_length,
    input wire ev_bad_fcs,
    input wire ev_parity_error,
    input wire ev_internal_fault,
    input wire sort_mode,
    input wire parity_check_enable,
    output wire input_unit_descriptor_valid,
    input wire input_unit_descriptor_ready,
    output wire [1:0] input_unit_descriptor_part,
    output wire [3:0] frame_status_code,
    output reg discard_active,
    output reg fault_seen
);
    // ----------------------------------------
    // Descriptor classification
    // ----------------------------------------
    reg in_frame_reg;
    reg in_frame_next;
    reg discard_next;
    reg fault_next;
    reg hdr_done_reg;
    reg hdr_done_next;
    reg info_started_reg;
    reg info_started_next;
    reg service_pend_reg;
    reg service_pend_next;
    reg [3:0] code;
    reg [1:0] part;
    reg emit;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [`RDSE_DESC_W-1:0] fifo_out_data;
    wire take;
    wire errored;
    wire space_abort;
    wire svc_event;
    wire hdr_seen;
    wire info_seen;

    function [1:0] part_of;
        input first;
        input last;
        begin
            case ({first, last})
                2'b11: part_of = `RDSE_PART_ONLY;
                2'b10: part_of = `RDSE_PART_FIRST;
                2'b01: part_of = `RDSE_PART_LAST;
                default: part_of = `RDSE_PART_MIDDLE;
            endcase
        end
    endfunction

    assign take = unit_valid && fifo_in_ready;
    assign unit_ready = fifo_in_ready;
    assign errored = ev_fifo_overrun || ev_bad_length || ev_bad_fcs
        || (ev_parity_error && parity_check_enable) || ev_internal_fault;
    assign space_abort = ev_no_data_space || ev_no_unit_space;
    assign svc_event = ev_mac_reset_event || ev_token || ev_mac_frame || ev_ring_op_change;
    // A first unit starts a new frame, so older header and info history is ignored.
    assign hdr_seen = hdr_done_reg && !unit_first;
    assign info_seen = info_started_reg && !unit_first;

    always @* begin
        code = `RDSE_ST_PAGE_CROSS;
        part = part_of(unit_first, 1'b0);
        emit = 1'b1;
        in_frame_next = in_frame_reg;
        discard_next = discard_active;
        fault_next = fault_seen;
        hdr_done_next = hdr_done_reg;
        info_started_next = info_started_reg;
        service_pend_next = service_pend_reg || svc_event;
        if (take) begin
            in_frame_next = !unit_frame_end;
            if (unit_first) begin
                discard_next = 1'b0;
                hdr_done_next = 1'b0;
                info_started_next = 1'b0;
            end
            if (discard_active && !unit_first) begin
                emit = 1'b0;
                if (unit_frame_end) begin
                    discard_next = 1'b0;
                end
            end else if (ev_internal_fault) begin
                code = `RDSE_ST_INTERNAL;
                part = part_of(unit_first, 1'b1);
                fault_next = 1'b1;
                discard_next = !unit_frame_end;
            end else if (ev_parity_error && parity_check_enable) begin
                code = `RDSE_ST_PARITY;
                part = part_of(unit_first, 1'b1);
                discard_next = !unit_frame_end;
            end else if (ev_fifo_overrun) begin
                code = `RDSE_ST_OVERRUN;
                part = part_of(unit_first, 1'b1);
                discard_next = !unit_frame_end;
            end else if (ev_bad_length || ev_bad_fcs) begin
                code = `RDSE_ST_BAD_FRAME;
                part = part_of(unit_first, 1'b1);
                discard_next = !unit_frame_end;
            end else if (space_abort && sort_mode && !hdr_seen
                && !unit_header_end) begin
                code = `RDSE_ST_NO_HDR;
                part = part_of(unit_first, 1'b1);
                discard_next = !unit_frame_end;
            end else if (space_abort && sort_mode && !info_seen) begin
                code = `RDSE_ST_HDR_NO_INFO;
                part = part_of(unit_first, 1'b1);
                discard_next = !unit_frame_end;
            end else if (space_abort && sort_mode) begin
                code = `RDSE_ST_NO_INFO;
                part = part_of(unit_first, 1'b1);
                discard_next = !unit_frame_end;
            end else if (ev_no_data_space) begin
                code = `RDSE_ST_NO_DATA;
                part = part_of(unit_first, 1'b1);
                discard_next = !unit_frame_end;
            end else if (unit_frame_end) begin
                part = part_of(unit_first, 1'b1);
                if (service_pend_next) begin
                    code = `RDSE_ST_NORM_SERVICE;
                    service_pend_next = svc_event;
                end else if (ev_threshold) begin
                    code = `RDSE_ST_NORM_THRESH;
                end else if (ev_burst_boundary) begin
                    code = `RDSE_ST_NORM_BURST;
                end else begin
                    code = `RDSE_ST_NORM_PLAIN;
                end
            end else if (unit_page_cross && unit_queue_last) begin
                code = `RDSE_ST_LAST_Q_PAGE;
                part = part_of(unit_first, 1'b1);
                discard_next = 1'b1;
            end else if (unit_page_cross && unit_header_end) begin
                code = `RDSE_ST_PAGE_HDR;
                hdr_done_next = 1'b1;
            end else if (unit_header_end) begin
                code = `RDSE_ST_HDR_END;
                hdr_done_next = 1'b1;
            end else if (unit_page_cross) begin
                code = `RDSE_ST_PAGE_CROSS;
            end else begin
                emit = 1'b0;
            end
            if (unit_is_info && !(discard_active && !unit_first)) begin
                info_started_next = 1'b1;
            end
        end else begin
            emit = 1'b0;
        end
    end

    // ----------------------------------------
    // State registers
    // ----------------------------------------
    always @(posedge core_clk) begin
        if (!rst_n) begin
            in_frame_reg <= 1'b0;
            discard_active <= 1'b0;
            fault_seen <= 1'b0;
            hdr_done_reg <= 1'b0;
            info_started_reg <= 1'b0;
            service_pend_reg <= 1'b0;
        end else begin
            in_frame_reg <= in_frame_next;
            discard_active <= discard_next;
            fault_seen <= fault_next;
            hdr_done_reg <= hdr_done_next;
            info_started_reg <= info_started_next;
            service_pend_reg <= service_pend_next;
        end
    end

    // ----------------------------------------
    // Descriptor buffer
    // ----------------------------------------
    rdse_fifo #(.WIDTH(`RDSE_DESC_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .in_valid(emit),
        .in_ready(fifo_in_ready),
        .in_data({part, code}),
        .out_valid(fifo_out_valid),
        .out_ready(input_unit_descriptor_ready),
        .out_data(fifo_out_data)
    );

    assign input_unit_descriptor_valid = fifo_out_valid;
    assign input_unit_descriptor_part =
        fifo_out_data[`RDSE_DESC_PART_HI:`RDSE_DESC_PART_LO];
    assign frame_status_code = fifo_out_data[`RDSE_DESC_STAT_HI:`RDSE_DESC_STAT_LO];
endmodule
